// ==== logic/gpef_pkg.sv ====
// Package for the port E upper pins and port F pin mux block.
// Assumes an APB slave with 32-bit data, registers one aligned word each.
package gpef_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [11:0] OFF_PORT_E_PIN_LEVELS_LEVELS = 12'h000;
    localparam logic [11:0] OFF_PORT_E_PIN_LEVELS_LATCH  = 12'h004;
    localparam logic [11:0] OFF_PORT_E_PIN_LEVELS_DIR    = 12'h008;
    localparam logic [11:0] OFF_PORT_F_PIN_LEVELS_LEVELS = 12'h00C;
    localparam logic [11:0] OFF_PORT_F_PIN_LEVELS_LATCH  = 12'h010;
    localparam logic [11:0] OFF_PORT_F_PIN_LEVELS_DIR    = 12'h014;
    localparam logic [11:0] OFF_CMP_CTRL     = 12'h018;
    localparam logic [11:0] OFF_CONV_CFG     = 12'h01C;
    localparam logic [11:0] OFF_PORTA_LATCH  = 12'h020;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_LATCH   = 8'h00;
    localparam logic [7:0] RST_DIR     = 8'hFF;
    localparam logic [7:0] RST_CMP     = 8'h00;
    localparam logic [7:0] RST_CONV    = 8'h00;
    localparam logic [7:0] RST_PORTA   = 8'h00;
    // ****************************************
    // Field positions and masks
    // ****************************************
    localparam int         CMP_EN_BIT    = 0;
    localparam logic [7:0] PORT_F_PIN_LEVELS_ANA_MSK = 8'h7E;
    localparam logic [7:0] PE_MSK_64     = 8'h3F;
    localparam logic [7:0] PF_MSK_SMALL  = 8'hFE;
    // ****************************************
    // Package variants
    // ****************************************
    typedef enum logic [1:0] {
        PKG_64  = 2'h0,
        PKG_80  = 2'h1,
        PKG_100 = 2'h2
    } gpef_pkg_type;
endpackage : gpef_pkg

// ==== logic/gpef_port_mux.sv ====
// Port E bits 5..7 and port F pin multiplexer with APB register access.
// Assumes pin inputs are asynchronous and peripheral signals share ref_clk.
//
// Contract
// R1: External bus overrides every other digital function when it owns a pin; unit 2 capture still reads E7.
// R2: E5..E7 carry bus bits 13..15 both ways, direction bit ignored.
// R3: External bus functions exist only on the 100-pin variant.
// R4: E5 drives PWM1 C, E6 PWM1 B at direction 0; shutdown tri-states.
// R5: PWM1 C/B sit on E5/E6 only when placement bit set, 80/100-pin.
// R6: E7 hosts unit 2 only when its placement bit clear, 80/100-pin.
// R7: Unit 2 on E7: direction 0 drives compare, direction 1 feeds capture.
// R8: PWM2 A on E7 drives at direction 0; shutdown tri-states.
// R9: Plain E pin: direction 0 drives latch, 1 is Schmitt input.
// R10: On 64-pin variant E6 and E7 register bits read zero.
// R11: Port F is bits 7..1 on 64/80-pin, eight bits on 100-pin.
// R12: F direction 1 tri-states the driver, 0 drives the latch.
// R13: F latch read returns latched value, not pin level.
// R14: Each F pin has Schmitt input and its own direction bit.
// R15: F7 has no analog role; F1..F6 serve the comparators.
// R16: F1..F6 are not digital inputs while comparators enabled.
// R17: After reset F1..F6 are analog and read zero.
// R18: Software disables comparators, then sets converter config to digital.
// R19: Port data write updates latch; read returns synchronised pin levels.
`timescale 1ns/1ps
module gpef_port_mux (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    // Device options, static straps
    input  wire gpef_pkg::gpef_pkg_type pkgVariant,
    input  wire logic                 pwmPinPlacementCfg,
    input  wire logic                 unit2PinPlacementCfg,
    input  wire logic                 microcontrollerMode,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // External memory bus, bits 13..15
    input  wire logic                 extBusOwn,
    input  wire logic                 extBusDrive,
    input  wire logic [2:0]           extBusOut,
    output logic [2:0]                extBusIn,
    // PWM and capture/compare
    input  wire logic                 pwmUnit1Active,
    input  wire logic                 pwmUnit1Shutdown,
    input  wire logic                 pwmUnit1ChannelC,
    input  wire logic                 pwmUnit1ChannelB,
    input  wire logic                 unit2CompareActive,
    input  wire logic                 unit2CompareOut,
    input  wire logic                 pwmUnit2Active,
    input  wire logic                 pwmUnit2Shutdown,
    input  wire logic                 pwmUnit2ChannelA,
    output logic                      unit2CaptureIn,
    // Comparator outputs on F1 and F2
    input  wire logic [1:0]           comparatorOut,
    // Port E bits 5..7 pins
    input  wire logic [2:0]           portEPinIn,
    output logic [2:0]                portEPinOut,
    output logic [2:0]                portEPinOe,
    // Port F pins
    input  wire logic [7:0]           portFPinIn,
    output logic [7:0]                portFPinOut,
    output logic [7:0]                portFPinOe,
    // Analog connection of F1..F6
    output logic [7:0]                portFAnalogSel
);
    import gpef_pkg::*;

    // ****************************************
    // Registers and synchronisers
    // ****************************************
    logic [7:0] portELatch;
    logic [7:0] portEDir;
    logic [7:0] portFLatch;
    logic [7:0] portFDir;
    logic [7:0] cmpCtrl;
    logic [7:0] convCfg;
    logic [7:0] portALatch;
    logic [2:0] eSync1;
    logic [2:0] eSync2;
    logic [7:0] fSync1;
    logic [7:0] fSync2;

    // ****************************************
    // Variant and ownership decode
    // ****************************************
    wire is100   = (pkgVariant == PKG_100);
    wire is64    = (pkgVariant == PKG_64);
    wire busOk   = is100 && extBusOwn;                                // R3
    wire pwm1Ok  = !is64 && pwmPinPlacementCfg && pwmUnit1Active;    // R5
    wire u2Place = !is64 && !unit2PinPlacementCfg
                   && microcontrollerMode;                            // R6
    wire cmpOn   = cmpCtrl[CMP_EN_BIT];
    wire [7:0] peMask = is64 ? PE_MSK_64 : 8'hFF;                     // R10
    wire [7:0] pfMask = is100 ? 8'hFF : PF_MSK_SMALL;                 // R11
    // Analog while converter config leaves it so, or comparators use it
    wire [7:0] fAnalog = (~convCfg | {8{cmpOn}}) & PORT_F_PIN_LEVELS_ANA_MSK;     // R15

    // ****************************************
    // Port E pin drive, fixed priority
    // ****************************************
    logic [2:0] next_eOut;
    logic [2:0] next_eOe;
    always_comb begin
        next_eOut = portELatch[7:5];
        next_eOe  = ~portEDir[7:5] & peMask[7:5];                    // R9
        if (pwm1Ok && !portEDir[5]) begin                            // R4
            next_eOut[0] = pwmUnit1ChannelC;
            next_eOe[0]  = !pwmUnit1Shutdown;
        end
        if (pwm1Ok && !portEDir[6]) begin                            // R4
            next_eOut[1] = pwmUnit1ChannelB;
            next_eOe[1]  = !pwmUnit1Shutdown;
        end
        if (u2Place && pwmUnit2Active && !portEDir[7]) begin         // R8
            next_eOut[2] = pwmUnit2ChannelA;
            next_eOe[2]  = !pwmUnit2Shutdown;
        end else if (u2Place && unit2CompareActive
                     && !portEDir[7]) begin                          // R7
            next_eOut[2] = unit2CompareOut;
            next_eOe[2]  = 1'b1;
        end
        if (busOk) begin                                             // R1
            next_eOut = extBusOut;                                   // R2
            next_eOe  = {3{extBusDrive}};                            // R2
        end
        next_eOe = next_eOe & peMask[7:5];
    end

    // ****************************************
    // Port F pin drive
    // ****************************************
    logic [7:0] next_fOut;
    always_comb begin
        next_fOut = portFLatch;
        // Comparator outputs take priority over latch data
        if (cmpOn) begin                                             // R15
            next_fOut[1] = comparatorOut[1];
            next_fOut[2] = comparatorOut[0];
        end
    end
    wire [7:0] next_fOe = ~portFDir & pfMask;                        // R12

    // ****************************************
    // Read values
    // ****************************************
    wire [7:0] eLevels = {eSync2, 5'h00} & peMask;                   // R19
    wire [7:0] fLevels = fSync2 & ~fAnalog & pfMask;                 // R16 R17
    logic [31:0] rdMux;
    logic        addrHit;
    always_comb begin
        addrHit = 1'b1;
        case (paddr)
            OFF_PORT_E_PIN_LEVELS_LEVELS: rdMux = {24'h0000_00, eLevels};
            OFF_PORT_E_PIN_LEVELS_LATCH:  rdMux = {24'h0000_00, portELatch & peMask};
            OFF_PORT_E_PIN_LEVELS_DIR:    rdMux = {24'h0000_00, portEDir & peMask};
            OFF_PORT_F_PIN_LEVELS_LEVELS: rdMux = {24'h0000_00, fLevels};
            OFF_PORT_F_PIN_LEVELS_LATCH:  rdMux = {24'h0000_00, portFLatch & pfMask};
            OFF_PORT_F_PIN_LEVELS_DIR:    rdMux = {24'h0000_00, portFDir & pfMask};
            OFF_CMP_CTRL:     rdMux = {24'h0000_00, cmpCtrl};
            OFF_CONV_CFG:     rdMux = {24'h0000_00, convCfg};
            OFF_PORTA_LATCH:  rdMux = {24'h0000_00, portALatch};
            default: begin
                rdMux   = 32'h0000_0000;
                addrHit = 1'b0;
            end
        endcase
    end
    wire access = psel && penable;
    // Writes land only on the completing access edge, never in setup
    wire wrEn   = access && pready && pwrite && addrHit;

    // ****************************************
    // Synchronisers
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            eSync1 <= 3'h0;
            eSync2 <= 3'h0;
            fSync1 <= 8'h00;
            fSync2 <= 8'h00;
        end else begin
            eSync1 <= portEPinIn;
            eSync2 <= eSync1;
            fSync1 <= portFPinIn;                                    // R14
            fSync2 <= fSync1;
        end
    end

    // ****************************************
    // Register writes, taken at the completing access edge
    // ****************************************
    // Writing the levels address lands in the latch, as on the real port
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            portELatch <= RST_LATCH;
            portEDir   <= RST_DIR;
            portFLatch <= RST_LATCH;
            portFDir   <= RST_DIR;
            cmpCtrl    <= RST_CMP;                                   // R17
            convCfg    <= RST_CONV;                                  // R17
            portALatch <= RST_PORTA;
        end else if (wrEn) begin
            case (paddr)
                OFF_PORT_E_PIN_LEVELS_LEVELS: portELatch <= pwdata[7:0];         // R19
                OFF_PORT_E_PIN_LEVELS_LATCH:  portELatch <= pwdata[7:0];
                OFF_PORT_E_PIN_LEVELS_DIR:    portEDir   <= pwdata[7:0];
                OFF_PORT_F_PIN_LEVELS_LEVELS: portFLatch <= pwdata[7:0];         // R19
                OFF_PORT_F_PIN_LEVELS_LATCH:  portFLatch <= pwdata[7:0];         // R13
                OFF_PORT_F_PIN_LEVELS_DIR:    portFDir   <= pwdata[7:0];         // R14
                OFF_CMP_CTRL:     cmpCtrl    <= pwdata[7:0];
                OFF_CONV_CFG:     convCfg    <= pwdata[7:0];
                OFF_PORTA_LATCH:  portALatch <= pwdata[7:0];
                default:          portALatch <= portALatch;
            endcase
        end
    end

    // ****************************************
    // APB answer: one wait-free access phase
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            prdata  <= (psel && !penable && !pwrite) ? rdMux : 32'h0000_0000;
            pslverr <= psel && !penable && !addrHit;
            if (access && pready) begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ****************************************
    // Registered pin outputs
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            portEPinOut    <= 3'h0;
            portEPinOe     <= 3'h0;
            portFPinOut    <= 8'h00;
            portFPinOe     <= 8'h00;
            portFAnalogSel <= PORT_F_PIN_LEVELS_ANA_MSK;                         // R17
            extBusIn       <= 3'h0;
            unit2CaptureIn <= 1'b0;
        end else begin
            portEPinOut    <= next_eOut;
            portEPinOe     <= next_eOe;
            portFPinOut    <= next_fOut;
            portFPinOe     <= next_fOe;
            portFAnalogSel <= fAnalog;
            extBusIn       <= busOk ? eSync2 : 3'h0;                 // R2
            unit2CaptureIn <= u2Place && portEDir[7] && eSync2[2];   // R7
        end
    end
endmodule : gpef_port_mux

// ==== tb/gpef_checker.sv ====
// Assertions for the port E/F pin mux, bound to its top-level ports.
// Assumes registered outputs and the single ref_clk domain.
`timescale 1ns/1ps
module gpef_checker
    import gpef_pkg::*;
(
    // Clock, reset and straps
    input wire logic                   ref_clk,
    input wire logic                   rstn,
    input wire gpef_pkg::gpef_pkg_type pkgVariant,
    input wire logic                   pwmPinPlacementCfg,
    // APB
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic                   pready,
    input wire logic [31:0]            prdata,
    // Pins and peripherals
    input wire logic                   extBusOwn,
    input wire logic                   extBusDrive,
    input wire logic [2:0]             extBusOut,
    input wire logic [2:0]             extBusIn,
    input wire logic                   pwmUnit1Active,
    input wire logic                   pwmUnit1Shutdown,
    input wire logic [2:0]             portEPinOut,
    input wire logic [2:0]             portEPinOe,
    input wire logic [7:0]             portFPinOe,
    input wire logic [7:0]             portFAnalogSel
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    property p_bus; pkgVariant == PKG_100 && extBusOwn && extBusDrive
        |=> portEPinOe == 3'h7 && portEPinOut == $past(extBusOut); endproperty
    a_bus: assert property (p_bus) else $error("bus not on pins");
    // Straps may change mid-run, so the input sync pipe is allowed to drain
    property p_noext; pkgVariant != PKG_100 [*3] |-> extBusIn == 3'h0;
    endproperty
    a_noext: assert property (p_noext) else $error("bus input live");
    property p_shut; pkgVariant != PKG_64 && pwmPinPlacementCfg &&
        pwmUnit1Active && pwmUnit1Shutdown && !extBusOwn
        |=> portEPinOe[1:0] == 2'h0; endproperty
    a_shut: assert property (p_shut) else $error("pwm not off");
    property p_arst; $rose(rstn) |-> portFAnalogSel == 8'h7E; endproperty
    a_arst: assert property (p_arst) else $error("F not analog");
    property p_ana; portFAnalogSel[7] == 1'b0 && !portFAnalogSel[0];
    endproperty
    a_ana: assert property (p_ana) else $error("bad analog pin");
    property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("answer timing");
    property p_e64; pkgVariant == PKG_64 && pready && !pwrite &&
        paddr <= OFF_PORT_E_PIN_LEVELS_DIR |-> prdata[7:6] == 2'h0; endproperty
    a_e64: assert property (p_e64) else $error("E7/E6 not zero");
    property p_f0; pkgVariant != PKG_100 [*2] |-> !portFPinOe[0]; endproperty
    a_f0: assert property (p_f0) else $error("F0 driven");
    property p_frd; pready && !pwrite && paddr == OFF_PORT_F_PIN_LEVELS_LEVELS
        |-> (prdata[7:0] & portFAnalogSel) == 8'h00; endproperty
    a_frd: assert property (p_frd) else $error("analog pin read");
    c_bus: cover property (extBusOwn && extBusDrive);
    c_shut: cover property (pwmUnit1Active && pwmUnit1Shutdown);
    c_e64: cover property (pkgVariant == PKG_64 && pready);
endmodule : gpef_checker
bind gpef_port_mux gpef_checker u_gpef_checker (.*);

// ==== tb/gpef_board.sv ====
// Board model for the port E and F pins.
// Assumes a driven pin shows the device level, a released one the board's.
`timescale 1ns/1ps
module gpef_board (
    // Device side of the pins
    input wire logic [2:0] portEPinOut,
    input wire logic [2:0] portEPinOe,
    input wire logic [7:0] portFPinOut,
    input wire logic [7:0] portFPinOe,
    // Levels the board applies to released pins
    input wire logic [2:0] boardE,
    input wire logic [7:0] boardF,
    // Resolved pin levels
    output logic [2:0]     portEPinIn,
    output logic [7:0]     portFPinIn
);
    assign portEPinIn = (portEPinOe & portEPinOut) | (~portEPinOe & boardE);
    assign portFPinIn = (portFPinOe & portFPinOut) | (~portFPinOe & boardF);
endmodule : gpef_board

// ==== tb/testbench.sv ====
// Self-checking bench for the port E/F pin mux over APB.
// Assumes the board model resolves pins and the checker is bound.
`timescale 1ns/1ps
module testbench;
    import gpef_pkg::*;
    logic         ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
    gpef_pkg_type pkgVariant;
    logic         pwmPinPlacementCfg, unit2PinPlacementCfg;
    logic         microcontrollerMode, extBusOwn, extBusDrive;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata;
    logic [2:0]   extBusOut, extBusIn, portEPinIn, portEPinOut;
    logic [2:0]   portEPinOe, boardE;
    logic         pwmUnit1Active, pwmUnit1Shutdown, pwmUnit1ChannelC;
    logic         pwmUnit1ChannelB, unit2CompareActive, unit2CompareOut;
    logic         pwmUnit2Active, pwmUnit2Shutdown, pwmUnit2ChannelA;
    logic         unit2CaptureIn;
    logic [1:0]   comparatorOut;
    logic [7:0]   portFPinIn, portFPinOut, portFPinOe, portFAnalogSel, boardF;
    int           fails = 0;
    int           num_checks = 0;
    gpef_port_mux u_gpef_port_mux (.*);
    gpef_board    u_gpef_board (.*);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [7:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // A read compares the masked data against d
    task automatic acc(input logic wr, input logic [11:0] a,
                       input logic [7:0] d, msk, input string nm);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        chk("pslverr", 8'(a > OFF_PORTA_LATCH), 8'(pslverr));
        if (!wr) chk(nm, d, prdata[7:0] & msk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : acc
    // One edge to launch the pin, two of sync, one to register, one to see
    task automatic pins;
        repeat (5) @(posedge ref_clk);
    endtask : pins
    task automatic test_done;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        test_done();
    end
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, extBusOwn, extBusDrive,
         extBusOut, pwmUnit1Active, pwmUnit1Shutdown, pwmUnit1ChannelC,
         pwmUnit1ChannelB, unit2CompareActive, unit2CompareOut,
         pwmUnit2Active, pwmUnit2Shutdown, pwmUnit2ChannelA,
         comparatorOut} = '0;
        {pwmPinPlacementCfg, unit2PinPlacementCfg, microcontrollerMode} = 3'h7;
        pkgVariant = PKG_100;
        boardE = 3'h5;
        boardF = 8'hFF;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        chk("anaSel", 8'h7E, portFAnalogSel);
        // Let the pin synchronisers fill before the first level read
        pins();
        acc(0, OFF_PORT_F_PIN_LEVELS_LEVELS, 8'h81, 8'hFF, "fLev");
        acc(0, OFF_PORT_E_PIN_LEVELS_DIR, RST_DIR, 8'hFF, "eDir");
        acc(0, 12'h100, 8'h00, 8'hFF, "unmapped");
        acc(1, OFF_CMP_CTRL, 8'h00, 8'h00, "");
        acc(1, OFF_CONV_CFG, 8'h7E, 8'h00, "");
        acc(1, OFF_PORT_F_PIN_LEVELS_LATCH, 8'hA5, 8'h00, "");
        acc(1, OFF_PORT_F_PIN_LEVELS_DIR, 8'hF0, 8'h00, "");
        boardF <= 8'h3C;
        pins();
        chk("fOe", 8'h0F, portFPinOe);
        chk("fOut", 8'h05, portFPinOut & 8'h0F);
        acc(0, OFF_PORT_F_PIN_LEVELS_LATCH, 8'hA5, 8'hFF, "fLat");
        acc(0, OFF_PORT_F_PIN_LEVELS_LEVELS, 8'h35, 8'hFF, "fLev");
        comparatorOut <= 2'h2;
        acc(1, OFF_CMP_CTRL, 8'h01, 8'h00, "");
        acc(0, OFF_PORT_F_PIN_LEVELS_LEVELS, 8'h01, 8'hFF, "fLevCmp");
        chk("fOutCmp", 8'hA3, portFPinOut);
        acc(1, OFF_CMP_CTRL, 8'h00, 8'h00, "");
        acc(1, OFF_PORT_F_PIN_LEVELS_LEVELS, 8'h5A, 8'h00, "");
        acc(0, OFF_PORT_F_PIN_LEVELS_LATCH, 8'h5A, 8'hFF, "fLat");
        pkgVariant <= PKG_80;
        acc(1, OFF_PORT_E_PIN_LEVELS_DIR, 8'h00, 8'h00, "");
        acc(1, OFF_PORT_E_PIN_LEVELS_LATCH, 8'hE0, 8'h00, "");
        pins();
        chk("eOe", 8'h07, 8'(portEPinOe));
        acc(0, OFF_PORT_E_PIN_LEVELS_LEVELS, 8'hE0, 8'hE0, "eLev");
        pwmUnit1Active <= 1'b1;
        pwmUnit1ChannelB <= 1'b1;
        pins();
        chk("eOut", 8'h06, 8'(portEPinOut));
        pwmPinPlacementCfg <= 1'b0;
        pins();
        chk("eOut", 8'h07, 8'(portEPinOut));
        pwmPinPlacementCfg <= 1'b1;
        pwmUnit1Shutdown <= 1'b1;
        pins();
        chk("eOe", 8'h04, 8'(portEPinOe));
        pwmUnit1Active <= 1'b0;
        unit2PinPlacementCfg <= 1'b0;
        unit2CompareActive <= 1'b1;
        pins();
        chk("eOut", 8'h03, 8'(portEPinOut));
        microcontrollerMode <= 1'b0;
        pins();
        chk("eOutNoU2", 8'h07, 8'(portEPinOut));
        microcontrollerMode <= 1'b1;
        pwmUnit2Active <= 1'b1;
        pwmUnit2ChannelA <= 1'b1;
        pins();
        chk("eOut", 8'h07, 8'(portEPinOut));
        pwmUnit2Shutdown <= 1'b1;
        pins();
        chk("eOe", 8'h03, 8'(portEPinOe));
        pwmUnit2Active <= 1'b0;
        boardE <= 3'h4;
        acc(1, OFF_PORT_E_PIN_LEVELS_DIR, 8'h80, 8'h00, "");
        pins();
        chk("capIn", 8'h01, 8'(unit2CaptureIn));
        acc(0, OFF_PORT_E_PIN_LEVELS_LEVELS, 8'h80, 8'h80, "eLev");
        pkgVariant <= PKG_100;
        {extBusOwn, extBusDrive, extBusOut} <= 5'h1A;
        pins();
        chk("eOe", 8'h07, 8'(portEPinOe));
        chk("eOut", 8'h02, 8'(portEPinOut));
        extBusDrive <= 1'b0;
        boardE <= 3'h3;
        pins();
        chk("busIn", 8'h03, 8'(extBusIn));
        pkgVariant <= PKG_80;
        pins();
        chk("busIn", 8'h00, 8'(extBusIn));
        extBusOwn <= 1'b0;
        pkgVariant <= PKG_64;
        acc(1, OFF_PORT_E_PIN_LEVELS_LATCH, 8'hFF, 8'h00, "");
        acc(0, OFF_PORT_E_PIN_LEVELS_LATCH, 8'h3F, 8'hFF, "eLat64");
        chk("fOe", 8'h0E, portFPinOe);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        chk("anaSel", 8'h7E, portFAnalogSel);
        acc(0, OFF_PORT_F_PIN_LEVELS_LEVELS, 8'h00, 8'hFF, "fLevRst");
        test_done();
    end
endmodule : testbench
